// ===== design/usmc_serial_ctrl.v
// serial transceiver with mode, control and status registers on APB
// assumes synchronous pin inputs on ref_clk; sclkIn doubles as external clock
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "usmc_consts.vh"

// How it works
// - mode field bits 7:6 pick async normal, multiprocessor, synchronous or LIN.
// - control bits 7/6 enable parity and pick odd; mode 0 or framed mode 2.
// - control bit 5 selects two stop bits in modes 0, 1, framed mode 2.
// - control bit 4 picks eight data bits over seven, modes 0 and 1 only.
// - control bit 3 marks address frames, only in multiprocessor mode.
// - writing 1 to clear-errors bit clears receive errors and resets receiver.
// - mode bit 4 picks external clock over internal clock for baud generator.
// - mode bit 5 with bit 4 set uses the external clock directly, bypassing the divider.
// - writing 1 to mode bit 3 restarts the baud generator; bit self-clears.
// - writing 1 to mode bit 2 resets the unit; bit self-clears.
// - mode bit 1 turns the clock pin into a clock output.
// - mode bit 0 turns the data pin into serial data output.
// - status bit 7 flags parity mismatch where parity applies.
// - status bit 6 flags a character completed while receive-full still set.
// - status bit 5 flags missing stop bit in modes 0, 1 and 3.
// - status bit 4 shows a received character is waiting.
// - status bit 3 shows transmit data register empty; one after reset.
// - status bit 2 selects msb-first shifting, not in LIN mode.
// - receive-full with receive interrupt enable raises receive request.
// - transmit-empty with transmit interrupt enable raises transmit request.
module usmc_serial_ctrl (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // serial pins
  input wire serialDataIn,
  input wire sclkIn,
  output reg serialDataOut,
  output reg serialDataOutEn,
  output reg sclkOut,
  output reg sclkOutEn,
  // interrupt requests
  output reg rxIrq,
  output reg txIrq
);

  // ************************************************************
  // register state
  // ************************************************************
  reg [7:0] control_q;
  reg [7:0] mode_q;
  reg [2:0] statusCfg_q;
  reg [14:0] baud_q;
  reg ext_q;
  reg [7:0] rxData_q;
  reg [7:0] txData_q;
  reg rxFull_q;
  reg txEmpty_q;
  reg parErr_q;
  reg ovrErr_q;
  reg frmErr_q;
  reg [31:0] rdMux;
  reg addrHit;

  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wrAcc = access & pwrite;
  wire rdAcc = access & ~pwrite;
  wire wrCtl = wrAcc & (paddr == `USMC_OFF_CONTROL);
  wire wrMod = wrAcc & (paddr == `USMC_OFF_MODE);
  wire wrSta = wrAcc & (paddr == `USMC_OFF_STATUS);
  wire wrDat = wrAcc & (paddr == `USMC_OFF_DATA);
  wire rdDat = rdAcc & (paddr == `USMC_OFF_DATA);
  wire clrErr = wrCtl & pwdata[`USMC_CTL_CLR_ERR];
  wire restart = wrMod & pwdata[`USMC_MOD_RESTART];
  wire unitRst = wrMod & pwdata[`USMC_MOD_SOFT_RST];

  // ************************************************************
  // configuration decode
  // ************************************************************
  wire [1:0] opMode = mode_q[`USMC_MOD_MODE_HI:`USMC_MOD_MODE_LO];
  wire isAsync = (opMode == `USMC_MODE_ASYNC);
  wire isMulti = (opMode == `USMC_MODE_MULTI);
  wire isSync = (opMode == `USMC_MODE_SYNC);
  wire isLin = (opMode == `USMC_MODE_LIN);
  wire framed = ~isSync | ext_q;
  wire parAct = control_q[`USMC_CTL_PARITY_EN] & (isAsync | (isSync & ext_q));
  wire parOdd = control_q[`USMC_CTL_PARITY_ODD];
  wire extraBit = parAct | isMulti;
  wire twoStop = control_q[`USMC_CTL_STOP_TWO] & ~isLin & framed;
  wire eightBit = control_q[`USMC_CTL_CHAR_EIGHT] | isSync | isLin;
  wire msbFirst = statusCfg_q[`USMC_STA_MSB_FIRST] & ~isLin;
  wire rxEn = control_q[`USMC_CTL_RX_EN];
  wire txEn = control_q[`USMC_CTL_TX_EN];
  wire extSel = mode_q[`USMC_MOD_EXT_SEL];
  wire extDirect = mode_q[`USMC_MOD_EXT_DIRECT];
  wire clkMaster = mode_q[`USMC_MOD_CLK_OE];
  wire [3:0] nData = eightBit ? 4'h8 : 4'h7;
  wire [3:0] frmOff = {3'h0, framed};
  wire [3:0] frmLen = frmOff + nData + {3'h0, extraBit} + (framed ? (twoStop ? 4'h2 : 4'h1) : 4'h0);
  wire [7:0] dataMask = eightBit ? 8'hff : 8'h7f;

  // ************************************************************
  // baud generator and external clock edges
  // ************************************************************
  reg sclkPrev_q;
  reg [14:0] bgCnt_q;
  wire sclkRise = sclkIn & ~sclkPrev_q;
  wire sclkFall = ~sclkIn & sclkPrev_q;
  wire baseTick = extSel ? sclkRise : 1'b1;
  wire [14:0] divEff = (extSel & extDirect) ? 15'h0000 : baud_q;
  wire bitTick = baseTick & (bgCnt_q == 15'h0000);

  always @(posedge ref_clk)
  begin
    sclkPrev_q <= sclkIn;
    if (rst | restart | unitRst)
    begin
      bgCnt_q <= divEff;
    end
    else if (bitTick)
    begin
      bgCnt_q <= divEff;
    end
    else if (baseTick)
    begin
      bgCnt_q <= bgCnt_q - 15'h0001;
    end
  end

  // ************************************************************
  // bit order reversal
  // ************************************************************
  wire [7:0] txRev;
  wire [7:0] rxOrd;
  wire [7:0] rxRev;
  wire [7:0] txSrc = eightBit ? txData_q : {txData_q[6:0], 1'b0};
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : gRev
      assign txRev[g] = txSrc[7 - g];
      assign rxRev[g] = rxOrd[7 - g];
    end
  endgenerate

  // ************************************************************
  // transmit frame assembly
  // ************************************************************
  reg [11:0] txFrm;
  reg [7:0] txOrd;
  integer i;
  always @*
  begin
    txOrd = msbFirst ? txRev : txData_q;
    txFrm = 12'hfff;
    if (framed)
    begin
      txFrm[0] = 1'b0;
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      if (i < nData)
      begin
        txFrm[frmOff + i] = txOrd[i];
      end
    end
    if (isMulti)
    begin
      txFrm[frmOff + nData] = control_q[`USMC_CTL_ADDRESS];
    end
    else if (parAct)
    begin
      txFrm[frmOff + nData] = (^(txData_q & dataMask)) ^ parOdd;
    end
  end

  // ************************************************************
  // transmitter
  // ************************************************************
  reg txBusy_q;
  reg [11:0] txShift_q;
  reg [3:0] txCnt_q;
  wire syncMasterTick = bitTick & clkMaster;
  wire txStep = isSync ? (clkMaster ? (syncMasterTick & (sclkOut | ~txBusy_q)) : sclkFall)
                       : bitTick;
  wire txLoad = txStep & ~(txBusy_q & (txCnt_q != 4'h0)) & ~txEmpty_q & txEn;

  always @(posedge ref_clk)
  begin
    if (rst | unitRst)
    begin
      txBusy_q <= 1'b0;
      txShift_q <= 12'hfff;
      txCnt_q <= 4'h0;
      serialDataOut <= 1'b1;
      sclkOut <= 1'b0;
    end
    else
    begin
      if (isSync & clkMaster & txBusy_q & syncMasterTick)
      begin
        sclkOut <= ~sclkOut;
      end
      else if (~isSync | ~clkMaster)
      begin
        sclkOut <= 1'b0;
      end
      if (txStep)
      begin
        if (txBusy_q & (txCnt_q != 4'h0))
        begin
          serialDataOut <= txShift_q[0];
          txShift_q <= {1'b1, txShift_q[11:1]};
          txCnt_q <= txCnt_q - 4'h1;
        end
        else if (txLoad)
        begin
          serialDataOut <= txFrm[0];
          txShift_q <= {1'b1, txFrm[11:1]};
          txCnt_q <= frmLen - 4'h1;
          txBusy_q <= 1'b1;
        end
        else
        begin
          txBusy_q <= 1'b0;
          if (~isSync)
          begin
            serialDataOut <= 1'b1;
          end
        end
      end
    end
  end

  // ************************************************************
  // receiver
  // ************************************************************
  reg rxBusy_q;
  reg [11:0] rxShift_q;
  reg [3:0] rxCnt_q;
  reg [14:0] rxTimer_q;
  wire syncSample = clkMaster ? (syncMasterTick & ~sclkOut & txBusy_q) : sclkRise;
  wire asyncSample = rxBusy_q & baseTick & (rxTimer_q == 15'h0000);
  wire rxSample = isSync ? syncSample : asyncSample;
  wire [11:0] rxShIn = {serialDataIn, rxShift_q[11:1]};
  wire rxStartA = ~isSync & ~rxBusy_q & ~serialDataIn;
  wire rxStartS = isSync & ~rxBusy_q & syncSample & (~ext_q | ~serialDataIn);
  wire rxLast = rxBusy_q & rxSample & (rxCnt_q == 4'h1);
  wire [11:0] rxFullFrm = rxShIn >> (4'hc - frmLen);
  wire [11:0] rxAl = rxFullFrm >> frmOff;
  assign rxOrd = rxAl[7:0];
  wire [7:0] rxWord = msbFirst ? (eightBit ? rxRev : {1'b0, rxRev[7:1]}) : (rxOrd & dataMask);
  wire rxParBit = rxAl[nData];
  wire rxStopBit = rxAl[nData + {3'h0, extraBit}];
  wire setPar = rxLast & parAct & (rxParBit != ((^(rxOrd & dataMask)) ^ parOdd));
  wire setFrm = rxLast & ~isSync & ~rxStopBit;
  wire setOvr = rxLast & rxFull_q;

  always @(posedge ref_clk)
  begin
    if (rst | unitRst | clrErr | ~rxEn)
    begin
      rxBusy_q <= 1'b0;
      rxShift_q <= 12'h000;
      rxCnt_q <= 4'h0;
      rxTimer_q <= 15'h0000;
    end
    else if (rxStartA)
    begin
      rxBusy_q <= 1'b1;
      rxCnt_q <= frmLen;
      rxTimer_q <= {1'b0, divEff[14:1]};
    end
    else if (rxStartS)
    begin
      rxShift_q <= rxShIn;
      rxCnt_q <= frmLen - 4'h1;
      rxBusy_q <= (frmLen != 4'h1);
    end
    else if (rxBusy_q)
    begin
      if (~isSync & baseTick)
      begin
        rxTimer_q <= (rxTimer_q == 15'h0000) ? divEff : rxTimer_q - 15'h0001;
      end
      if (rxSample)
      begin
        rxShift_q <= rxShIn;
        rxCnt_q <= rxCnt_q - 4'h1;
        if (rxLast)
        begin
          rxBusy_q <= 1'b0;
        end
        else if (~isSync & (rxCnt_q == frmLen) & serialDataIn)
        begin
          rxBusy_q <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // registers and flags
  // ************************************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      control_q <= `USMC_RST_CONTROL;
      mode_q <= `USMC_RST_MODE;
      statusCfg_q <= `USMC_RST_STATUS_CFG;
      baud_q <= `USMC_RST_BAUD;
      ext_q <= `USMC_RST_EXT;
      txData_q <= 8'h00;
      rxData_q <= 8'h00;
      txEmpty_q <= 1'b1;
      rxFull_q <= 1'b0;
      parErr_q <= 1'b0;
      ovrErr_q <= 1'b0;
      frmErr_q <= 1'b0;
    end
    else
    begin
      if (wrCtl)
      begin
        control_q <= pwdata[7:0] & 8'hfb;
      end
      if (wrMod)
      begin
        mode_q <= pwdata[7:0] & 8'hf3;
      end
      if (wrSta)
      begin
        statusCfg_q <= pwdata[2:0];
      end
      if (wrAcc & (paddr == `USMC_OFF_BAUD))
      begin
        baud_q <= pwdata[14:0];
      end
      if (wrAcc & (paddr == `USMC_OFF_EXT))
      begin
        ext_q <= pwdata[`USMC_EXT_SYNC_FRAMING];
      end
      if (unitRst)
      begin
        txEmpty_q <= 1'b1;
        rxFull_q <= 1'b0;
        parErr_q <= 1'b0;
        ovrErr_q <= 1'b0;
        frmErr_q <= 1'b0;
      end
      else
      begin
        if (wrDat)
        begin
          txData_q <= pwdata[7:0];
        end
        txEmpty_q <= txLoad | (txEmpty_q & ~wrDat);
        rxFull_q <= rxLast | (rxFull_q & ~rdDat);
        if (rxLast & ~rxFull_q)
        begin
          rxData_q <= rxWord;
        end
        parErr_q <= setPar | (parErr_q & ~clrErr);
        ovrErr_q <= setOvr | (ovrErr_q & ~clrErr);
        frmErr_q <= setFrm | (frmErr_q & ~clrErr);
      end
    end
  end

  // ************************************************************
  // pins and interrupt requests
  // ************************************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      serialDataOutEn <= 1'b0;
      sclkOutEn <= 1'b0;
      rxIrq <= 1'b0;
      txIrq <= 1'b0;
    end
    else
    begin
      serialDataOutEn <= mode_q[`USMC_MOD_DAT_OE];
      sclkOutEn <= mode_q[`USMC_MOD_CLK_OE];
      rxIrq <= rxFull_q & statusCfg_q[`USMC_STA_RX_IE];
      txIrq <= txEmpty_q & statusCfg_q[`USMC_STA_TX_IE];
    end
  end

  // ************************************************************
  // apb read path and answer
  // ************************************************************
  always @*
  begin
    rdMux = 32'h00000000;
    addrHit = 1'b1;
    case (paddr)
      `USMC_OFF_CONTROL: rdMux[7:0] = control_q;
      `USMC_OFF_MODE: rdMux[7:0] = mode_q;
      `USMC_OFF_STATUS: rdMux[7:0] = {parErr_q, ovrErr_q, frmErr_q, rxFull_q, txEmpty_q,
                                      statusCfg_q};
      `USMC_OFF_DATA: rdMux[7:0] = rxData_q;
      `USMC_OFF_BAUD: rdMux[14:0] = baud_q;
      `USMC_OFF_EXT: rdMux[0] = ext_q;
      default: addrHit = 1'b0;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~addrHit;
      if (setup)
      begin
        prdata <= rdMux;
      end
    end
  end

endmodule // usmc_serial_ctrl

// ===== design/usmc_consts.vh
// register offsets, field positions, reset values and mode codes of the serial
// transceiver control block; assumes a byte-addressed APB with 32-bit data
`ifndef USMC_CONSTS_VH
`define USMC_CONSTS_VH

// register byte offsets
`define USMC_OFF_CONTROL 8'h00
`define USMC_OFF_MODE 8'h04
`define USMC_OFF_STATUS 8'h08
`define USMC_OFF_DATA 8'h0c
`define USMC_OFF_BAUD 8'h10
`define USMC_OFF_EXT 8'h14

// control register fields
`define USMC_CTL_PARITY_EN 7
`define USMC_CTL_PARITY_ODD 6
`define USMC_CTL_STOP_TWO 5
`define USMC_CTL_CHAR_EIGHT 4
`define USMC_CTL_ADDRESS 3
`define USMC_CTL_CLR_ERR 2
`define USMC_CTL_RX_EN 1
`define USMC_CTL_TX_EN 0

// mode register fields
`define USMC_MOD_MODE_HI 7
`define USMC_MOD_MODE_LO 6
`define USMC_MOD_EXT_DIRECT 5
`define USMC_MOD_EXT_SEL 4
`define USMC_MOD_RESTART 3
`define USMC_MOD_SOFT_RST 2
`define USMC_MOD_CLK_OE 1
`define USMC_MOD_DAT_OE 0

// status register fields
`define USMC_STA_PARITY_ERR 7
`define USMC_STA_OVERRUN 6
`define USMC_STA_FRAMING 5
`define USMC_STA_RX_FULL 4
`define USMC_STA_TX_EMPTY 3
`define USMC_STA_MSB_FIRST 2
`define USMC_STA_RX_IE 1
`define USMC_STA_TX_IE 0

// extension register fields
`define USMC_EXT_SYNC_FRAMING 0

// operating modes
`define USMC_MODE_ASYNC 2'h0
`define USMC_MODE_MULTI 2'h1
`define USMC_MODE_SYNC 2'h2
`define USMC_MODE_LIN 2'h3

// reset values
`define USMC_RST_CONTROL 8'h00
`define USMC_RST_MODE 8'h00
`define USMC_RST_STATUS_CFG 3'h0
`define USMC_RST_BAUD 15'h000f
`define USMC_RST_EXT 1'h0

`endif

// ===== bench/usmc_serial_ctrl_props.sv
// port checker for the serial control block
// assumes one ref_clk domain with synchronous active-high rst
`timescale 1ns/10ps
// ****************
// port checker
// ****************
module usmc_serial_ctrl_props (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // serial pins
  input wire serialDataIn,
  input wire sclkIn,
  input wire serialDataOut,
  input wire serialDataOutEn,
  input wire sclkOut,
  input wire sclkOutEn,
  // interrupt requests
  input wire rxIrq,
  input wire txIrq
);
  wire setupCyc = psel && !penable;
  wire unmapped = (paddr[1:0] != 2'h0) || (paddr > 8'h14);
  wire wrDone = psel && penable && pready && pwrite;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_ready_after_setup: assert property (setupCyc |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_error_decode: assert property (setupCyc |=> pslverr == unmapped)
    else $error("slave error does not match decode");
  a_error_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_read_upper_zero: assert property (pready && !pwrite && paddr != 8'h10 |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_data_pin_enable:
    assert property (wrDone && paddr == 8'h04 |-> ##2 serialDataOutEn == $past(pwdata[0], 2))
    else $error("data pin enable wrong");
  a_clock_pin_enable:
    assert property (wrDone && paddr == 8'h04 |-> ##2 sclkOutEn == $past(pwdata[1], 2))
    else $error("clock pin enable wrong");
  a_tx_irq_mask:
    assert property (wrDone && paddr == 8'h08 && !pwdata[0] |-> ##2 !txIrq)
    else $error("masked transmit request high");
  a_rx_irq_mask:
    assert property (wrDone && paddr == 8'h08 && !pwdata[1] |-> ##2 !rxIrq)
    else $error("masked receive request high");
endmodule // usmc_serial_ctrl_props
bind usmc_serial_ctrl usmc_serial_ctrl_props chk (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serialDataIn(serialDataIn), .sclkIn(sclkIn), .serialDataOut(serialDataOut),
  .serialDataOutEn(serialDataOutEn), .sclkOut(sclkOut), .sclkOutEn(sclkOutEn),
  .rxIrq(rxIrq), .txIrq(txIrq));

// ===== bench/usmc_remote_node.sv
// remote asynchronous transceiver facing the serial pins
// assumes bit time of BITCYC ref_clk cycles, lsb first
`timescale 1ns/10ps
// ****************
// remote node
// ****************
module usmc_remote_node #(
  parameter BITCYC = 8
) (
  // clock
  input wire ref_clk,
  // serial lines
  input wire txLine,
  output reg rxLine,
  output reg clkLine
);
  // line idles at mark level, clock stands still
  initial
  begin
    rxLine = 1'b1;
    clkLine = 1'b0;
  end
  task sendFrame(input [7:0] d, input usePar, input par, input stopBit);
    integer i;
    reg [10:0] f;
    begin
      f = {stopBit, par, d, 1'b0};
      for (i = 0; i < 11; i = i + 1)
      begin
        if (i != 9 || usePar)
        begin
          @(posedge ref_clk);
          rxLine <= f[i];
          repeat (BITCYC - 1) @(posedge ref_clk);
        end
      end
      @(posedge ref_clk);
      rxLine <= 1'b1;
    end
  endtask
  task recvBits(output [9:0] v);
    integer i;
    integer w;
    begin
      w = 0;
      v = 10'bx;
      while (txLine !== 1'b0 && w < 400)
      begin
        @(posedge ref_clk);
        w = w + 1;
      end
      if (w < 400)
      begin
        repeat (BITCYC / 2) @(posedge ref_clk);
        for (i = 0; i < 10; i = i + 1)
        begin
          repeat (BITCYC) @(posedge ref_clk);
          v[i] = txLine;
        end
      end
    end
  endtask
endmodule // usmc_remote_node

// ===== bench/usmc_serial_ctrl_tb.sv
// self-checking bench of the serial control block
// assumes APB master here, remote node on the serial pins
`timescale 1ns/10ps
`include "usmc_consts.vh"
`define CHK(nm, e, g) begin cmpCount = cmpCount + 1; if ((g) !== (e)) begin \
  mismatches = mismatches + 1; $display("ERROR %s expected %h seen %h", nm, e, g); end end
// ****************
// bench top
// ****************
module usmc_serial_ctrl_tb;
  localparam [7:0] CTRL = `USMC_OFF_CONTROL;
  localparam [7:0] MODE = `USMC_OFF_MODE;
  localparam [7:0] STAT = `USMC_OFF_STATUS;
  localparam [7:0] DATA = `USMC_OFF_DATA;
  localparam [7:0] BAUD = `USMC_OFF_BAUD;
  reg ref_clk, rst, psel, penable, pwrite, lastErr;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  reg [9:0] frame;
  wire [31:0] prdata;
  wire pready, pslverr, serialDataIn, sclkIn, serialDataOut;
  wire serialDataOutEn, sclkOut, sclkOutEn, rxIrq, txIrq;
  integer mismatches, cmpCount, m;
  usmc_serial_ctrl dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialDataIn(serialDataIn), .sclkIn(sclkIn),
    .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn), .sclkOut(sclkOut),
    .sclkOutEn(sclkOutEn), .rxIrq(rxIrq), .txIrq(txIrq));
  usmc_remote_node #(.BITCYC(8)) peer (.ref_clk(ref_clk), .txLine(serialDataOut),
    .rxLine(serialDataIn), .clkLine(sclkIn));
  always #4 ref_clk = ~ref_clk;
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
      if (mismatches == 0 && cmpCount > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge ref_clk);
        n = n + 1;
      end
      rd = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
        mismatches = mismatches + 1;
        test_done;
      end
    end
  endtask
  task chkRd(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      `CHK("regRead", e, rd)
    end
  endtask
  task testReset;
    begin
      chkRd(CTRL, 32'h00);
      chkRd(MODE, 32'h00);
      chkRd(STAT, 32'h08);
      chkRd(BAUD, 32'h0f);
      apb(1'b0, 8'h18, 32'h0);
      `CHK("slvErr", 1'b1, lastErr)
      `CHK("txIrqReset", 1'b0, txIrq)
      $display("test reset done");
    end
  endtask
  task testModes;
    begin
      for (m = 0; m < 4; m = m + 1)
      begin
        apb(1'b1, MODE, {24'h0, m[1:0], m[1:0], 4'h0});
        chkRd(MODE, {24'h0, m[1:0], m[1:0], 4'h0});
      end
      apb(1'b1, MODE, 32'h0f);
      chkRd(MODE, 32'h03);
      `CHK("dataPinEn", 1'b1, serialDataOutEn)
      `CHK("clkPinEn", 1'b1, sclkOutEn)
      $display("test modes done");
    end
  endtask
  task txCase(input [7:0] md, input [7:0] c, input [7:0] s, input [7:0] d, input [9:0] e);
    begin
      apb(1'b1, CTRL, 32'h0);
      apb(1'b1, MODE, {24'h0, md | 8'h04});
      apb(1'b1, STAT, {24'h0, s});
      apb(1'b1, BAUD, 32'h07);
      apb(1'b1, CTRL, {24'h0, c});
      apb(1'b1, DATA, {24'h0, d});
      peer.recvBits(frame);
      `CHK("txFrame", e, frame)
      apb(1'b0, STAT, 32'h0);
      `CHK("txEmpty", 1'b1, rd[3])
    end
  endtask
  task testRx;
    begin
      txCase(8'h01, 8'h11, 8'h02, 8'ha5, 10'h3a5);
      apb(1'b1, CTRL, 32'hd2);
      peer.sendFrame(8'h3c, 1'b1, 1'b1, 1'b1);
      chkRd(STAT, 32'h1a);
      `CHK("rxIrq", 1'b1, rxIrq)
      chkRd(DATA, 32'h3c);
      chkRd(STAT, 32'h0a);
      peer.sendFrame(8'h3c, 1'b1, 1'b0, 1'b1);
      chkRd(STAT, 32'h9a);
      peer.sendFrame(8'h81, 1'b1, 1'b1, 1'b0);
      chkRd(STAT, 32'hfa);
      chkRd(DATA, 32'h3c);
      apb(1'b1, CTRL, 32'hd2);
      chkRd(STAT, 32'hea);
      apb(1'b1, CTRL, 32'hd6);
      chkRd(STAT, 32'h0a);
      apb(1'b1, STAT, 32'h01);
      repeat (3) @(posedge ref_clk);
      `CHK("txIrq", 1'b1, txIrq)
      $display("test receive done");
    end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    mismatches = 0;
    cmpCount = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    testReset;
    testModes;
    txCase(8'h01, 8'h11, 8'h00, 8'ha5, 10'h3a5);
    txCase(8'h01, 8'h11, 8'h04, 8'h0f, 10'h3f0);
    txCase(8'h01, 8'h01, 8'h00, 8'h0f, 10'h38f);
    txCase(8'h41, 8'h19, 8'h00, 8'h00, 10'h300);
    txCase(8'h41, 8'h11, 8'h00, 8'h00, 10'h200);
    txCase(8'h01, 8'h91, 8'h00, 8'h01, 10'h301);
    txCase(8'h01, 8'hd1, 8'h00, 8'h01, 10'h201);
    txCase(8'hc1, 8'h01, 8'h04, 8'h0f, 10'h30f);
    $display("test transmit done");
    testRx;
    test_done;
  end
endmodule // usmc_serial_ctrl_tb
